// File: core/abct_master.sv
// processor end: runs strobe sequence and decodes cycle termination
// assumes handshake inputs already synchronous to i_clock
`default_nettype none
module abct_master
    import abct_pkg::*;
#(
    parameter int unsigned AW = abct_pkg::ABCT_AW_DEF,
    parameter int unsigned DW = abct_pkg::ABCT_DW_DEF
) (
    input  wire logic          i_clock,
    input  wire logic          i_nrst,
    abct_if.master             bus,
    input  wire logic          i_req,
    input  wire logic          i_write,
    input  wire logic [1:0]    i_lanes,
    input  wire logic [AW-1:0] i_addr,
    input  wire logic [DW-1:0] i_wdata,
    input  wire logic          i_late_variant,
    output logic               o_busy,
    output logic               o_done,
    output logic [DW-1:0]      o_rdata,
    output logic               o_bus_error,
    output logic               o_illegal,
    output logic [7:0]         o_vector,
    output logic               o_halted
);
    typedef struct packed {
        abct_mst_state_t st;
        abct_term_t      term;
        logic            as_n;
        logic            uds_n;
        logic            lds_n;
        logic            ds_n;
        logic            rw;
        logic            d_oe;
        logic [AW-1:0]   addr;
        logic [DW-1:0]   wdata;
        logic [1:0]      lanes;
        logic            write;
        logic            late;
        logic            halt_after;
        logic [DW-1:0]   rdata;
        logic            busy;
        logic            done;
        logic            bus_fault_input;
        logic            ill;
        logic [7:0]      vec;
        logic            halted;
    } abct_mst_reg_t;

    abct_mst_reg_t r;
    abct_mst_reg_t n;
    logic          ack;
    logic          fault;
    logic          stop;
    logic          fin;

    assign ack   = (bus.transfer_ack_n == ABCT_ON);
    assign fault = (bus.bus_fault_input_n == ABCT_ON);
    assign stop  = (bus.stop_input_n == ABCT_ON);

    always_comb begin
        n        = r;
        fin      = 1'b0;
        n.done   = 1'b0;
        n.bus_fault_input   = 1'b0;
        n.ill    = 1'b0;
        case (r.st)
            M_IDLE: begin
                // a stop left asserted holds off the next cycle
                if (i_req && !stop) begin
                    n.st    = M_ADDR;
                    n.addr  = i_addr;
                    n.wdata = i_wdata;
                    n.lanes = i_lanes;
                    n.write = i_write;
                    n.late  = i_late_variant;
                    n.rw    = ABCT_RD;
                end
            end
            M_ADDR: begin
                n.term       = TERM_NORMAL;
                n.halt_after = 1'b0;
                n.as_n       = ABCT_ON;
                if (r.write) begin
                    n.rw = ~ABCT_RD;
                    n.st = M_DATA;
                end else begin
                    n.uds_n = ~r.lanes[1];
                    n.lds_n = ~r.lanes[0];
                    n.st    = M_WAIT;
                end
            end
            M_DATA: begin
                n.d_oe = 1'b1;
                n.st   = M_STRB;
            end
            M_STRB: begin
                // data has stood a full clock before strobes
                n.uds_n = ~r.lanes[1];
                n.lds_n = ~r.lanes[0];
                n.st    = M_WAIT;
            end
            M_WAIT: begin
                // no time limit here: wait states until answered
                if (fault && stop) begin
                    n.term = TERM_RETRY;
                    fin    = 1'b1;
                end else if (fault) begin
                    n.term = TERM_BUS_FAULT_INPUT;
                    fin    = 1'b1;
                end else if (ack) begin
                    n.rdata      = bus.data;
                    n.halt_after = stop;
                    if (r.late) begin
                        n.st = M_HOLD;
                    end else begin
                        fin = 1'b1;
                    end
                end
            end
            M_HOLD: begin
                // one extra clock to catch a late fault
                if (fault && stop) begin
                    n.term = TERM_RETRY;
                end else if (fault) begin
                    n.term = TERM_BUS_FAULT_INPUT;
                end else begin
                    n.halt_after = r.halt_after | stop;
                end
                fin = 1'b1;
            end
            M_END: begin
                case (r.term)
                    TERM_BUS_FAULT_INPUT:  n.st = M_ERRW;
                    TERM_RETRY: n.st = M_RTRY;
                    default: begin
                        n.done = 1'b1;
                        n.st   = r.halt_after ? M_HALTW : M_IDLE;
                    end
                endcase
            end
            M_HALTW: begin
                if (!stop) begin
                    n.st = M_IDLE;
                end
            end
            M_ERRW: begin
                if (!fault && !stop) begin
                    n.bus_fault_input = 1'b1;
                    n.st   = M_IDLE;
                end
            end
            M_RTRY: begin
                if (!fault && stop) begin
                    n.st = M_RSTOP;
                end else if (!stop) begin
                    // stop released first or together with fault
                    n.ill = 1'b1;
                    n.vec = ABCT_ILL_VEC;
                    n.st  = M_IDLE;
                end
            end
            M_RSTOP: begin
                if (!stop) begin
                    n.rw = ABCT_RD;
                    n.st = M_ADDR;
                end
            end
            default: begin
                n.st = M_IDLE;
            end
        endcase
        if (fin) begin
            n.st    = M_END;
            n.as_n  = ABCT_OFF;
            n.uds_n = ABCT_OFF;
            n.lds_n = ABCT_OFF;
            n.d_oe  = 1'b0;
            n.rw    = ABCT_RD;
        end
        n.ds_n   = n.uds_n & n.lds_n;
        n.busy   = (n.st != M_IDLE);
        n.halted = (n.st == M_HALTW);
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            r      <= '0;
            r.st   <= M_IDLE;
            r.term <= TERM_NORMAL;
            r.as_n <= ABCT_OFF;
            r.uds_n <= ABCT_OFF;
            r.lds_n <= ABCT_OFF;
            r.ds_n <= ABCT_OFF;
            r.rw   <= ABCT_RD;
        end else begin
            r <= n;
        end
    end

    assign bus.address_strobe_n     = r.as_n;
    assign bus.upper_byte_strobe_n  = r.uds_n;
    assign bus.lower_byte_strobe_n  = r.lds_n;
    assign bus.single_byte_strobe_n = r.ds_n;
    assign bus.rw                   = r.rw;
    assign bus.addr                 = r.addr;
    assign bus.m_data               = r.wdata;
    assign bus.m_oe                 = r.d_oe;
    assign o_busy                   = r.busy;
    assign o_done                   = r.done;
    assign o_rdata                  = r.rdata;
    assign o_bus_error              = r.bus_fault_input;
    assign o_illegal                = r.ill;
    assign o_vector                 = r.vec;
    assign o_halted                 = r.halted;
endmodule
`default_nettype wire

// File: core/abct_pkg.sv
// constants and types shared by both ends of the asynchronous bus
// assumes one processor clock for both ends; handshake pins are active low
`default_nettype none
package abct_pkg;
    localparam int unsigned ABCT_AW_DEF   = 23;
    localparam int unsigned ABCT_DW_DEF   = 16;
    localparam int unsigned ABCT_CW       = 8;
    localparam int unsigned ABCT_WDOG_DEF = 16;
    localparam int unsigned ABCT_HOLD_DEF = 2;
    localparam logic        ABCT_ON       = 1'b0;
    localparam logic        ABCT_OFF      = 1'b1;
    localparam logic        ABCT_RD       = 1'b1;
    localparam logic [7:0]  ABCT_ILL_VEC  = 8'h00;

    typedef enum logic [3:0] {
        M_IDLE  = 4'h0,
        M_ADDR  = 4'h1,
        M_DATA  = 4'h3,
        M_STRB  = 4'h2,
        M_WAIT  = 4'h6,
        M_HOLD  = 4'h7,
        M_END   = 4'h5,
        M_HALTW = 4'h4,
        M_ERRW  = 4'hc,
        M_RTRY  = 4'hd,
        M_RSTOP = 4'hf
    } abct_mst_state_t;

    typedef enum logic [1:0] {
        TERM_NORMAL = 2'h0,
        TERM_BUS_FAULT_INPUT   = 2'h1,
        TERM_RETRY  = 2'h2
    } abct_term_t;

    typedef enum logic [2:0] {
        RSP_NORMAL     = 3'h0,
        RSP_HALT       = 3'h1,
        RSP_BUS_FAULT_INPUT       = 3'h2,
        RSP_RETRY      = 3'h3,
        RSP_LATE_BUS_FAULT_INPUT  = 3'h4,
        RSP_LATE_RETRY = 3'h5,
        RSP_ABSENT     = 3'h6
    } abct_rsp_t;

    typedef enum logic [1:0] {
        S_IDLE = 2'h0,
        S_WAIT = 2'h1,
        S_RESP = 2'h3,
        S_STOP = 2'h2
    } abct_slv_state_t;
endpackage
`default_nettype wire

// File: core/abct_if.sv
// wires between the processor end and the slave/control end
// data bus level is resolved here from the two output enables
`default_nettype none
interface abct_if #(
    parameter int unsigned AW = abct_pkg::ABCT_AW_DEF,
    parameter int unsigned DW = abct_pkg::ABCT_DW_DEF
);
    logic          address_strobe_n;
    logic          upper_byte_strobe_n;
    logic          lower_byte_strobe_n;
    logic          single_byte_strobe_n;
    logic          rw;
    logic [AW-1:0] addr;
    logic [DW-1:0] m_data;
    logic          m_oe;
    logic [DW-1:0] s_data;
    logic          s_oe;
    logic [DW-1:0] data;
    logic          transfer_ack_n;
    logic          bus_fault_input_n;
    logic          stop_input_n;

    // undriven bus floats high
    assign data = m_oe ? m_data : (s_oe ? s_data : '1);

    modport master (
        output address_strobe_n, upper_byte_strobe_n, lower_byte_strobe_n,
        output single_byte_strobe_n, rw, addr, m_data, m_oe,
        input  data, transfer_ack_n, bus_fault_input_n, stop_input_n
    );
    modport slave (
        input  address_strobe_n, upper_byte_strobe_n, lower_byte_strobe_n,
        input  single_byte_strobe_n, rw, addr, data,
        output s_data, s_oe, transfer_ack_n, bus_fault_input_n, stop_input_n
    );
endinterface
`default_nettype wire

// File: core/abct_slave.sv
// slave and bus control end: answers each cycle as i_mode selects
// assumes master strobes are synchronous to i_clock
`default_nettype none
module abct_slave
    import abct_pkg::*;
#(
    parameter int unsigned AW   = abct_pkg::ABCT_AW_DEF,
    parameter int unsigned DW   = abct_pkg::ABCT_DW_DEF,
    parameter int unsigned WDOG = abct_pkg::ABCT_WDOG_DEF,
    parameter int unsigned HOLD = abct_pkg::ABCT_HOLD_DEF
) (
    input  wire logic                  i_clock,
    input  wire logic                  i_nrst,
    abct_if.slave                      bus,
    input  wire abct_pkg::abct_rsp_t   i_mode,
    input  wire logic [ABCT_CW-1:0]    i_delay,
    input  wire logic [DW-1:0]         i_rdata,
    output logic [AW-1:0]              o_addr,
    output logic [DW-1:0]              o_wdata,
    output logic [1:0]                 o_lanes,
    output logic                       o_wr_pulse,
    output logic                       o_rd_pulse,
    output logic                       o_active
);
    typedef struct packed {
        abct_slv_state_t    st;
        abct_rsp_t          mode;
        logic [ABCT_CW-1:0] cnt;
        logic [ABCT_CW-1:0] hold;
        logic               ack_n;
        logic               fault_n;
        logic               stop_n;
        logic               s_oe;
        logic [DW-1:0]      s_d;
        logic               late;
        logic [AW-1:0]      addr;
        logic [DW-1:0]      wdata;
        logic [1:0]         lanes;
        logic               wr;
        logic               rd;
        logic               active;
    } abct_slv_reg_t;

    abct_slv_reg_t r;
    abct_slv_reg_t n;
    logic          as_on;
    logic          strb_on;
    logic          ready;

    assign as_on   = (bus.address_strobe_n == ABCT_ON);
    assign strb_on = (bus.upper_byte_strobe_n == ABCT_ON) || (bus.lower_byte_strobe_n == ABCT_ON);
    // a write is only taken once the strobes say data is valid
    assign ready   = (bus.rw == ABCT_RD) || strb_on;

    always_comb begin
        n    = r;
        n.wr = 1'b0;
        n.rd = 1'b0;
        case (r.st)
            S_IDLE: begin
                if (as_on) begin
                    n.mode = i_mode;
                    n.addr = bus.addr;
                    n.cnt  = '0;
                    n.st   = S_WAIT;
                    if (bus.rw == ABCT_RD) begin
                        n.s_oe = 1'b1;
                        n.s_d  = i_rdata;
                    end
                end
            end
            S_WAIT: begin
                if (!as_on) begin
                    n.s_oe = 1'b0;
                    n.st   = S_IDLE;
                end else if (ready) begin
                    if (r.cnt == '0 && bus.rw != ABCT_RD) begin
                        n.wdata = bus.data;
                        n.lanes = {bus.upper_byte_strobe_n == ABCT_ON,
                                   bus.lower_byte_strobe_n == ABCT_ON};
                        n.wr    = 1'b1;
                    end
                    n.cnt = r.cnt + 1'b1;
                    if (r.mode == RSP_ABSENT) begin
                        // watchdog stands in for the missing slave
                        if (r.cnt == ABCT_CW'(WDOG - 1)) begin
                            n.fault_n = ABCT_ON;
                            n.st      = S_RESP;
                        end
                    end else if (r.cnt >= i_delay) begin
                        n.st = S_RESP;
                        n.rd = (bus.rw == ABCT_RD);
                        case (r.mode)
                            RSP_HALT: begin
                                n.ack_n  = ABCT_ON;
                                n.stop_n = ABCT_ON;
                            end
                            RSP_BUS_FAULT_INPUT: begin
                                n.ack_n   = ABCT_ON;
                                n.fault_n = ABCT_ON;
                            end
                            RSP_RETRY: begin
                                n.fault_n = ABCT_ON;
                                n.stop_n  = ABCT_ON;
                            end
                            RSP_LATE_BUS_FAULT_INPUT, RSP_LATE_RETRY: begin
                                n.ack_n = ABCT_ON;
                                n.late  = 1'b1;
                            end
                            default: begin
                                n.ack_n = ABCT_ON;
                            end
                        endcase
                    end
                end
            end
            S_RESP: begin
                if (r.late) begin
                    // one clock after the acknowledge
                    n.late    = 1'b0;
                    n.fault_n = ABCT_ON;
                    if (r.mode == RSP_LATE_RETRY) begin
                        n.stop_n = ABCT_ON;
                    end
                end
                if (!as_on) begin
                    n.ack_n   = ABCT_OFF;
                    n.fault_n = ABCT_OFF;
                    n.s_oe    = 1'b0;
                    n.late    = 1'b0;
                    n.hold    = '0;
                    n.st      = (n.stop_n == ABCT_ON) ? S_STOP : S_IDLE;
                end
            end
            S_STOP: begin
                n.hold = r.hold + 1'b1;
                if (r.hold >= ABCT_CW'(HOLD - 1)) begin
                    n.stop_n = ABCT_OFF;
                    n.st     = S_IDLE;
                end
            end
            default: begin
                n.st = S_IDLE;
            end
        endcase
        n.active = (n.st != S_IDLE);
    end

    // every handshake change outside the asynchronous reset is on the rising edge
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            r         <= '0;
            r.st      <= S_IDLE;
            r.mode    <= RSP_NORMAL;
            r.ack_n   <= ABCT_OFF;
            r.fault_n <= ABCT_OFF;
            r.stop_n  <= ABCT_OFF;
        end else begin
            r <= n;
        end
    end

    assign bus.transfer_ack_n    = r.ack_n;
    assign bus.bus_fault_input_n = r.fault_n;
    assign bus.stop_input_n      = r.stop_n;
    assign bus.s_oe              = r.s_oe;
    assign bus.s_data            = r.s_d;
    assign o_addr                = r.addr;
    assign o_wdata               = r.wdata;
    assign o_lanes               = r.lanes;
    assign o_wr_pulse            = r.wr;
    assign o_rd_pulse            = r.rd;
    assign o_active              = r.active;
endmodule
`default_nettype wire

// File: dv/abct_bus_asserts.sv
// checker on the wires between the processor end and the slave end
// assumes one clock and the active-low handshake levels of the package
`default_nettype none
module abct_bus_chk #(
    parameter int unsigned DW = 16
) (
    input wire logic          i_clock,
    input wire logic          i_nrst,
    input wire logic          address_strobe_n,
    input wire logic          upper_byte_strobe_n,
    input wire logic          lower_byte_strobe_n,
    input wire logic          single_byte_strobe_n,
    input wire logic          rw,
    input wire logic          m_oe,
    input wire logic [DW-1:0] m_data,
    input wire logic [DW-1:0] data,
    input wire logic          transfer_ack_n,
    input wire logic          bus_fault_input_n,
    input wire logic          stop_input_n
);
    timeunit 1ns;
    timeprecision 1ps;
    wire logic lane_n = upper_byte_strobe_n & lower_byte_strobe_n;

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_nrst);

    a_strobe_in_cycle: assert property (
        !lane_n |-> !address_strobe_n) else $error("lane strobe outside a cycle");
    a_strobes_drop_together: assert property (
        $rose(address_strobe_n) |-> lane_n) else $error("lane strobe left low");
    a_single_tracks_lanes: assert property (
        single_byte_strobe_n == lane_n) else $error("single strobe off its lanes");
    a_write_data_valid: assert property (
        !rw && !lane_n |-> m_oe && data == m_data) else $error("strobe without write data");
    a_data_before_strobe: assert property (
        !rw && $fell(lane_n) |-> $past(m_oe)) else $error("strobe with data just driven");
    a_dir_before_drive: assert property (
        $rose(m_oe) |-> !rw && !$past(rw) && !address_strobe_n)
        else $error("data driven before direction");
    a_wait_unbounded: assert property (
        !address_strobe_n && transfer_ack_n && bus_fault_input_n |=> !address_strobe_n)
        else $error("cycle ended without answer");
    a_ack_ends_cycle: assert property (
        !address_strobe_n && !transfer_ack_n && bus_fault_input_n
        |-> ##[1:2] address_strobe_n) else $error("acknowledge did not end cycle");
    a_fault_ends_cycle: assert property (
        !address_strobe_n && !bus_fault_input_n |-> ##[1:2] address_strobe_n)
        else $error("fault did not end cycle");
    a_stop_blocks_start: assert property (
        address_strobe_n && !stop_input_n |=> address_strobe_n)
        else $error("cycle started under stop");
    a_ack_released: assert property (
        $rose(address_strobe_n) |-> ##[1:3] transfer_ack_n && bus_fault_input_n)
        else $error("answer held after strobe release");
    a_stop_outlasts_fault: assert property (
        $rose(bus_fault_input_n) && !stop_input_n |=> !stop_input_n)
        else $error("stop released with fault");
endmodule
`default_nettype wire

// File: dv/tb.sv
// bench: both ends joined on one set of wires, plus a lone processor end
// whose far side the bench drives by hand to break the release order
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import abct_pkg::*;

    logic        clk, nrst, req, req2, wr, late, busy, done, bus_fault_input, ill, halted;
    logic        busy2, done2, berr2, ill2, as_q, wrp, rdp;
    logic [1:0]  lanes, s_lanes;
    logic [22:0] addr, s_addr;
    logic [15:0] wdata, rdin, rdata, s_wdata;
    logic [7:0]  vec, vec2, dly;
    logic [2:0]  res;
    abct_rsp_t   mode;
    int          failures, num_checks, as_falls, halt_cyc, n, f0, wr_cnt, rd_cnt;

    abct_if bus_if ();
    abct_if bus2_if ();

    abct_master abct_master_i (.i_clock(clk), .i_nrst(nrst),
        .bus(bus_if.master), .i_req(req), .i_write(wr), .i_lanes(lanes), .i_addr(addr),
        .i_wdata(wdata), .i_late_variant(late), .o_busy(busy), .o_done(done),
        .o_rdata(rdata), .o_bus_error(bus_fault_input), .o_illegal(ill), .o_vector(vec),
        .o_halted(halted));
    abct_slave #(.WDOG(4)) abct_slave_i (.i_clock(clk),
        .i_nrst(nrst), .bus(bus_if.slave), .i_mode(mode), .i_delay(dly), .i_rdata(rdin),
        .o_addr(s_addr), .o_wdata(s_wdata), .o_lanes(s_lanes), .o_wr_pulse(wrp),
        .o_rd_pulse(rdp), .o_active());
    // second name needed: same module on the hand-driven wires
    abct_master abct_master_i2 (.i_clock(clk), .i_nrst(nrst),
        .bus(bus2_if.master), .i_req(req2), .i_write(wr), .i_lanes(lanes), .i_addr(addr),
        .i_wdata(wdata), .i_late_variant(1'b0), .o_busy(busy2), .o_done(done2),
        .o_rdata(), .o_bus_error(berr2), .o_illegal(ill2), .o_vector(vec2), .o_halted());
    abct_bus_chk abct_chk_i (.i_clock(clk), .i_nrst(nrst),
        .address_strobe_n(bus_if.address_strobe_n),
        .upper_byte_strobe_n(bus_if.upper_byte_strobe_n),
        .lower_byte_strobe_n(bus_if.lower_byte_strobe_n),
        .single_byte_strobe_n(bus_if.single_byte_strobe_n), .rw(bus_if.rw),
        .m_oe(bus_if.m_oe), .m_data(bus_if.m_data), .data(bus_if.data),
        .transfer_ack_n(bus_if.transfer_ack_n), .bus_fault_input_n(bus_if.bus_fault_input_n),
        .stop_input_n(bus_if.stop_input_n));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // strobe starts count reruns
    always @(posedge clk) begin
        as_q <= bus_if.address_strobe_n;
        if (as_q && !bus_if.address_strobe_n)
            as_falls++;
        if (halted === 1'b1)
            halt_cyc++;
        if (wrp === 1'b1)
            wr_cnt++;
        if (rdp === 1'b1)
            rd_cnt++;
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic stall();
        failures++;
        complete_run();
    endtask

    // retry modes fall back to a plain answer once the fault shows
    task automatic outcome(input logic lone);
        res = 3'h0;
        for (n = 0; n < 300 && res == 3'h0; n++) begin
            @(posedge clk);
            if (!bus_if.bus_fault_input_n)
                mode <= RSP_NORMAL;
            #1;
            res = lone ? {ill2, berr2, done2} : {ill, bus_fault_input, done};
        end
        if (res == 3'h0)
            stall();
    endtask

    task automatic cyc(input logic w, input abct_rsp_t m, input logic [7:0] d,
                       input logic [1:0] ln, input logic [2:0] exp);
        for (n = 0; n < 50 && (busy !== 1'b0 || bus_if.stop_input_n !== 1'b1); n++)
            @(posedge clk);
        if (n == 50)
            stall();
        @(posedge clk);
        req <= 1'b1;
        wr <= w;
        mode <= m;
        dly <= d;
        lanes <= ln;
        addr <= {13'h0, d, ln};
        wdata <= {d, 8'h5a};
        rdin <= {8'hc3, d};
        @(posedge clk);
        req <= 1'b0;
        outcome(1'b0);
        chk("outcome", res, exp);
    endtask

    task automatic wait2(input logic lvl);
        for (n = 0; n < 50 && bus2_if.address_strobe_n !== lvl; n++)
            @(posedge clk);
        if (n == 50)
            stall();
    endtask

    task automatic go2();
        for (n = 0; n < 50 && busy2 !== 1'b0; n++)
            @(posedge clk);
        if (n == 50)
            stall();
        @(posedge clk);
        req2 <= 1'b1;
        @(posedge clk);
        req2 <= 1'b0;
        wait2(1'b0);
    endtask

    initial begin
        {nrst, req, req2, wr, late} = 5'h00;
        {lanes, addr, wdata, rdin, dly} = '0;
        mode = RSP_NORMAL;
        {failures, num_checks} = '0;
        {bus2_if.transfer_ack_n, bus2_if.bus_fault_input_n, bus2_if.stop_input_n} = 3'h7;
        bus2_if.s_oe = 1'b0;
        bus2_if.s_data = 16'h0000;
        repeat (10) @(posedge clk);
        chk("strobe in reset", bus_if.address_strobe_n, 1'b1);
        nrst <= 1'b1;
        for (int i = 1; i < 4; i++) begin
            cyc(1'b1, RSP_NORMAL, 8'h00, i[1:0], 3'h1);
            chk("write time", n, 6);
            chk("write data", s_wdata, wdata);
            chk("write lanes", s_lanes, i[1:0]);
            chk("address", s_addr, addr);
            cyc(1'b0, RSP_NORMAL, 8'h00, i[1:0], 3'h1);
            chk("read time", n, 5);
            chk("read data", rdata, rdin);
        end
        chk("write pulses", wr_cnt, 3);
        chk("read pulses", rd_cnt, 3);
        $display("test lanes done");
        cyc(1'b0, RSP_NORMAL, 8'h14, 2'h3, 3'h1);
        chk("wait time", n, 25);
        cyc(1'b0, RSP_HALT, 8'h00, 2'h3, 3'h1);
        cyc(1'b0, RSP_NORMAL, 8'h00, 2'h3, 3'h1);
        chk("halted", halt_cyc != 0, 1);
        chk("resumed", halted, 1'b0);
        $display("test halt done");
        cyc(1'b0, RSP_BUS_FAULT_INPUT, 8'h02, 2'h3, 3'h2);
        cyc(1'b1, RSP_ABSENT, 8'h00, 2'h3, 3'h2);
        f0 = as_falls;
        cyc(1'b0, RSP_RETRY, 8'h01, 2'h3, 3'h1);
        chk("retry starts", as_falls - f0, 2);
        chk("retry data", rdata, rdin);
        $display("test fault done");
        @(posedge clk);
        late <= 1'b1;
        cyc(1'b0, RSP_LATE_BUS_FAULT_INPUT, 8'h00, 2'h3, 3'h2);
        f0 = as_falls;
        cyc(1'b1, RSP_LATE_RETRY, 8'h00, 2'h3, 3'h1);
        chk("late retry starts", as_falls - f0, 2);
        $display("test late done");
        go2();
        bus2_if.bus_fault_input_n <= 1'b0;
        bus2_if.stop_input_n <= 1'b0;
        repeat (2) @(posedge clk);
        bus2_if.stop_input_n <= 1'b1;
        // illegal pulse lands on the second edge after stop release
        outcome(1'b1);
        chk("wrong order", res, 3'h4);
        chk("vector", vec2, 8'h00);
        @(posedge clk);
        bus2_if.bus_fault_input_n <= 1'b1;
        go2();
        bus2_if.bus_fault_input_n <= 1'b0;
        bus2_if.stop_input_n <= 1'b0;
        repeat (2) @(posedge clk);
        bus2_if.bus_fault_input_n <= 1'b1;
        repeat (2) @(posedge clk);
        bus2_if.stop_input_n <= 1'b1;
        wait2(1'b1);
        wait2(1'b0);
        bus2_if.transfer_ack_n <= 1'b0;
        outcome(1'b1);
        chk("rerun", res, 3'h1);
        @(posedge clk);
        bus2_if.transfer_ack_n <= 1'b1;
        bus2_if.bus_fault_input_n <= 1'b0;
        go2();
        repeat (2) @(posedge clk);
        bus2_if.bus_fault_input_n <= 1'b1;
        outcome(1'b1);
        chk("fault left low", res, 3'h2);
        $display("test lone end done");
        complete_run();
    end
endmodule
`default_nettype wire
